/* File: tomg_cfg.svh */
// Register offsets, field positions and reset values of the output gating block.
// Assumes inclusion by bare name from every file that needs the numbers.
`ifndef TOMG_CFG_SVH
`define TOMG_CFG_SVH

// Byte offsets on the register bus.
`define TOMG_OFS_OUT_MASTER_EN 4'h0
`define TOMG_OFS_OUT_CONTROL   4'h4
`define TOMG_OFS_COMBO_MODE    4'h8

// Reset values.
`define TOMG_RST_OUT_MASTER_EN 8'hFF
`define TOMG_RST_OUT_CONTROL   8'hFF
`define TOMG_RST_COMBO_MODE    2'h0

// Bits that always read as one and ignore writes.
`define TOMG_OME_FIXED_ONES    8'hC0
`define TOMG_OCR_FIXED_ONES    8'hEC

// Field positions.
`define TOMG_OME_PIN_BITS      6'h3F
`define TOMG_OCR_EXT_TRIG_DIS  4
`define TOMG_OCR_LEVEL_INV_CH4 1
`define TOMG_OCR_LEVEL_INV_CH3 0
`define TOMG_MODE_COMBO_HI     1
`define TOMG_MODE_COMBO_LO     0

`endif

/* File: tomg_pkg.sv */
// Types shared by the output gating block and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package tomg_pkg;

    // Combination mode of the paired channels.
    typedef enum logic [1:0] {
        TOMG_MODE_NORMAL0 = 2'h0,
        TOMG_MODE_NORMAL1 = 2'h1,
        TOMG_MODE_COMPL   = 2'h2,
        TOMG_MODE_RESYNC  = 2'h3
    } tomg_mode_t;

    // One classic Wishbone request from the master.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } tomg_wb_req_t;

    // Six pins: driven level and output enable, index 0 to 5 is
    // ch3_a, ch4_a, ch4_b, ch3_b, ch4_compl_a, ch4_compl_b.
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } tomg_pins_t;

endpackage : tomg_pkg

`default_nettype wire

/* File: tomg_gate.sv */
// Output master gating for the paired timer channels 3 and 4, with its
// three software registers on a classic Wishbone slave port.
// Assumes timer waveforms, port I/O values, the capture event and the
// standby request all come from logic on clk_i.
`include "tomg_cfg.svh"
`default_nettype none

module tomg_gate #(
    parameter int PIN_N = 6
) (
    // Clock and reset.
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave.
    input  wire tomg_pkg::tomg_wb_req_t wb_req_i,
    output var  logic [31:0]           wb_dat_o,
    output var  logic                  wb_ack_o,
    // Timer core events and waveforms.
    input  wire logic                  standby_i,
    input  wire logic                  ch1_capture_a_i,
    input  wire logic [PIN_N-1:0]      tmr_out_i,
    input  wire logic [PIN_N-1:0]      tmr_oe_i,
    // General port I/O values used while a pin is not enabled.
    input  wire logic [PIN_N-1:0]      gpio_out_i,
    input  wire logic [PIN_N-1:0]      gpio_oe_i,
    // Pins.
    output var  tomg_pkg::tomg_pins_t  pins_o,
    output var  logic [1:0]            combo_mode_o
);

    // Register state.
    logic [7:0]  ome_r;
    logic [7:0]  ome_nxt;
    logic [7:0]  ocr_r;
    logic [7:0]  ocr_nxt;
    logic [1:0]  mode_r;
    logic [1:0]  mode_nxt;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic [PIN_N-1:0] pin_out_r;
    logic [PIN_N-1:0] pin_oe_r;
    wire  [PIN_N-1:0] pin_out_nxt;
    wire  [PIN_N-1:0] pin_oe_nxt;

    // Matching an offset is used by every decode below.
    function automatic logic adr_hit(input logic [3:0] adr, input logic [3:0] ofs);
        adr_hit = (adr == ofs);
    endfunction : adr_hit

    // Bus request decode; a write lands on the edge that sees ack high.
    wire        req_w      = wb_req_i.cyc && wb_req_i.stb;
    wire        wr_fire    = req_w && wb_req_i.we && ack_r && wb_req_i.sel[0];
    wire        hit_ome    = adr_hit(wb_req_i.adr, `TOMG_OFS_OUT_MASTER_EN);
    wire        hit_ocr    = adr_hit(wb_req_i.adr, `TOMG_OFS_OUT_CONTROL);
    wire        hit_mode   = adr_hit(wb_req_i.adr, `TOMG_OFS_COMBO_MODE);
    wire        wr_ome     = wr_fire && hit_ome;
    wire        wr_ocr     = wr_fire && hit_ocr;
    wire        wr_mode    = wr_fire && hit_mode;
    wire [7:0]  wbyte      = wb_req_i.dat[7:0];

    wire        combo_on   = mode_r[`TOMG_MODE_COMBO_HI];
    wire        mode_compl = (tomg_pkg::tomg_mode_t'(mode_r) == tomg_pkg::TOMG_MODE_COMPL);
    wire        mode_rsync = (tomg_pkg::tomg_mode_t'(mode_r) == tomg_pkg::TOMG_MODE_RESYNC);

    wire        xtg_dis    = ocr_r[`TOMG_OCR_EXT_TRIG_DIS];
    // trigger acts only in combined modes, when enabled.
    wire        trig_fire  = ch1_capture_a_i && !xtg_dis && (mode_compl || mode_rsync);

    // Read data multiplexer; unmapped offsets read zero.
    wire [7:0]  rd_byte    = hit_ome  ? ome_r :
                             hit_ocr  ? ocr_r :
                             hit_mode ? {6'h00, mode_r} : 8'h00;

    // Level inversion groups; in the combined modes an invert bit at zero flips the level.
    wire        inv_ch4    = combo_on && !ocr_r[`TOMG_OCR_LEVEL_INV_CH4];
    wire        inv_ch3    = combo_on && !ocr_r[`TOMG_OCR_LEVEL_INV_CH3];
    wire [PIN_N-1:0] inv_mask = {inv_ch3, inv_ch3, inv_ch3, inv_ch4, inv_ch4, inv_ch4};

    // Next value of the master enable register. Standby outranks everything,
    // and the hardware clear is applied after the write so it wins.
    always_comb begin
        ome_nxt = ome_r;
        if (wr_ome) begin
            ome_nxt = wbyte | `TOMG_OME_FIXED_ONES;
        end
        if (trig_fire) begin
            ome_nxt = ome_nxt & ~{2'b00, `TOMG_OME_PIN_BITS};
        end
        if (standby_i) begin
            ome_nxt = `TOMG_RST_OUT_MASTER_EN;
        end
    end

    // Next value of the output control and mode registers.
    always_comb begin
        ocr_nxt  = ocr_r;
        mode_nxt = mode_r;
        if (wr_ocr) begin
            ocr_nxt = wbyte | `TOMG_OCR_FIXED_ONES;
        end
        if (wr_mode) begin
            mode_nxt = wbyte[1:0];
        end
        if (standby_i) begin
            ocr_nxt  = `TOMG_RST_OUT_CONTROL;
            mode_nxt = `TOMG_RST_COMBO_MODE;
        end
    end

    // Register update.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ome_r  <= `TOMG_RST_OUT_MASTER_EN;
            ocr_r  <= `TOMG_RST_OUT_CONTROL;
            mode_r <= `TOMG_RST_COMBO_MODE;
        end else begin
            ome_r  <= ome_nxt;
            ocr_r  <= ocr_nxt;
            mode_r <= mode_nxt;
        end
    end

    // Bus answer: ack one cycle after the request, dropped the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= req_w && !ack_r;
            rdat_r <= (req_w && !ack_r) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Per-pin selection between timer and port I/O. An enable bit at one
    // passes the timer waveform with its group inversion applied.
    genvar k;
    generate
        for (k = 0; k < PIN_N; k++) begin : g_pin
            assign pin_out_nxt[k] = ome_r[k] ? (tmr_out_i[k] ^ inv_mask[k]) : gpio_out_i[k];
            assign pin_oe_nxt[k]  = ome_r[k] ? tmr_oe_i[k] : gpio_oe_i[k];
        end
    endgenerate

    // Pin stage. Registering the pins costs one cycle of latency but keeps
    // decode glitches off the power-stage drivers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_out_r <= '0;
            pin_oe_r  <= '0;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

    // Output drive, all straight from flip-flops.
    assign wb_ack_o     = ack_r;
    assign wb_dat_o     = rdat_r;
    assign pins_o.out   = pin_out_r;
    assign pins_o.oe    = pin_oe_r;
    assign combo_mode_o = mode_r;

    // Checks of the gating behaviour.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ome_after_reset: assert property (
        $past(rst_i) |-> (ome_r == 8'hFF) && (ocr_r == 8'hFF))
        else $error("Registers not all ones after reset.");

    a_standby_all_ones: assert property (
        standby_i |=> (ome_r == 8'hFF) && (ocr_r == 8'hFF) && (mode_r == 2'h0))
        else $error("Standby did not set registers.");

    a_fixed_one_bits: assert property (
        (ome_r[7:6] == 2'b11) && (ocr_r[7:5] == 3'b111))
        else $error("Reserved bits lost their ones.");

    a_ocr_write_keeps: assert property (
        wr_ocr && !standby_i |=> (ocr_r[4:0] == ($past(wbyte[4:0]) | 5'h0C)))
        else $error("Output control write stored wrongly.");

    a_trig_clears_en: assert property (
        ch1_capture_a_i && !xtg_dis && mode_r[1] && !standby_i |=> (ome_r[5:0] == 6'h00))
        else $error("Trigger did not clear enables.");

    a_trig_dis_holds: assert property (
        ch1_capture_a_i && xtg_dis && !wr_ome && !standby_i |=> $stable(ome_r))
        else $error("Disabled trigger changed enables.");

    a_normal_no_trig: assert property (
        ch1_capture_a_i && !mode_r[1] && !wr_ome && !standby_i |=> $stable(ome_r))
        else $error("Trigger acted outside combined modes.");

    a_hw_beats_sw: assert property (
        trig_fire && wr_ome && !standby_i |=> (ome_r == 8'hC0))
        else $error("Software write beat hardware clear.");

    a_gate_port_io: assert property (
        ome_r[3] == 1'b0 |=> (pins_o.out[3] == $past(gpio_out_i[3]))
                             && (pins_o.oe[3] == $past(gpio_oe_i[3])))
        else $error("Gated pin did not follow port I/O.");

    a_normal_no_inv: assert property (
        !mode_r[1] && ome_r[0] |=> (pins_o.out[0] == $past(tmr_out_i[0])))
        else $error("Level changed in normal mode.");

    a_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held longer than one cycle.");

    // Bus handshake: ack follows a fresh request, and read data rests at zero.
    a_ack_after_req: assert property (
        req_w && !wb_ack_o |=> wb_ack_o)
        else $error("Request not acknowledged in the next cycle.");

    a_dat_idle_zero: assert property (
        !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
        else $error("Read data not zero outside ack.");

    a_ome_write_store: assert property (
        wr_ome && !trig_fire && !standby_i |=> (ome_r == ($past(wbyte) | 8'hC0)))
        else $error("Master enable write stored wrongly.");

    a_mode_write_store: assert property (
        wr_mode && !standby_i |=> (mode_r == $past(wbyte[1:0])))
        else $error("Mode write stored wrongly.");

    // Each gated pin hands over to port I/O while its enable bit is low.
    a_gate_compl_b: assert property (
        ome_r[5] == 1'b0 |=> (pins_o.out[5] == $past(gpio_out_i[5]))
                             && (pins_o.oe[5] == $past(gpio_oe_i[5])))
        else $error("Gated complementary B pin did not follow port I/O.");

    a_gate_compl_a: assert property (
        ome_r[4] == 1'b0 |=> (pins_o.out[4] == $past(gpio_out_i[4]))
                             && (pins_o.oe[4] == $past(gpio_oe_i[4])))
        else $error("Gated complementary A pin did not follow port I/O.");

    a_gate_ch4_b: assert property (
        ome_r[2] == 1'b0 |=> (pins_o.out[2] == $past(gpio_out_i[2]))
                             && (pins_o.oe[2] == $past(gpio_oe_i[2])))
        else $error("Gated channel 4 B pin did not follow port I/O.");

    a_gate_ch4_a: assert property (
        ome_r[1] == 1'b0 |=> (pins_o.out[1] == $past(gpio_out_i[1]))
                             && (pins_o.oe[1] == $past(gpio_oe_i[1])))
        else $error("Gated channel 4 A pin did not follow port I/O.");

    a_gate_ch3_a: assert property (
        ome_r[0] == 1'b0 |=> (pins_o.out[0] == $past(gpio_out_i[0]))
                             && (pins_o.oe[0] == $past(gpio_oe_i[0])))
        else $error("Gated channel 3 A pin did not follow port I/O.");

    a_timer_oe_b: assert property (
        ome_r[5] |=> (pins_o.oe[5] == $past(tmr_oe_i[5])))
        else $error("Enabled complementary B pin lost timer enable.");

    a_timer_oe_a: assert property (
        ome_r[0] |=> (pins_o.oe[0] == $past(tmr_oe_i[0])))
        else $error("Enabled channel 3 A pin lost timer enable.");

    // Level inversion in the combined modes, per group.
    a_inv_ch3_grp: assert property (
        mode_r[1] && !ocr_r[0] && ome_r[3] |=> (pins_o.out[3] == !$past(tmr_out_i[3])))
        else $error("Channel 3 group level not inverted.");

    a_inv_ch4_grp: assert property (
        mode_r[1] && !ocr_r[1] && ome_r[1] |=> (pins_o.out[1] == !$past(tmr_out_i[1])))
        else $error("Channel 4 group level not inverted.");

    a_direct_ch4_lvl: assert property (
        mode_r[1] && ocr_r[1] && ome_r[2] |=> (pins_o.out[2] == $past(tmr_out_i[2])))
        else $error("Channel 4 group level inverted when direct.");

endmodule : tomg_gate

`default_nettype wire

/* File: tomg_pin_model.sv */
// Power-stage driver model that sits on the six gated timer pins.
// Assumes pins_i comes from the gating block on the same clock.
`default_nettype none

module tomg_pin_model (
    // Pins from the gating block.
    input  wire tomg_pkg::tomg_pins_t pins_i,
    // Level seen at each driver input.
    output var  logic [5:0]           lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // A released pin falls to the driver's pull-down, so a stale level never shows.
    always_comb begin
        lvl_o = pins_i.out & pins_i.oe;
    end
endmodule : tomg_pin_model

`default_nettype wire

/* File: tomg_tb.sv */
// Self-checking bench for the output gating block, its register port and its pins.
// Assumes a 100 MHz clock and a synchronous active-high reset.
`include "tomg_cfg.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk_i, rst_i, standby_i, cap_r, wb_ack;
    logic [5:0]             tout, toe, gout, goe, lvl;
    logic [31:0]            rdat, seed, wb_dat;
    logic [7:0]             ome_m, ocr_m;
    logic [1:0]             mode_m, combo;
    tomg_pkg::tomg_wb_req_t req;
    tomg_pkg::tomg_pins_t   pins;
    int                     err_total, n_tests, cyc_n;

    tomg_gate #(.PIN_N(6)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .standby_i(standby_i),
        .ch1_capture_a_i(cap_r), .tmr_out_i(tout), .tmr_oe_i(toe), .gpio_out_i(gout),
        .gpio_oe_i(goe), .pins_o(pins), .combo_mode_o(combo));
    tomg_pin_model u_drv (.pins_i(pins), .lvl_o(lvl));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One classic cycle; trig pulses the capture event into the edge that takes the write.
    task automatic acc(input logic we, input logic [3:0] adr, input logic [7:0] d,
                       input logic trig);
        logic [7:0] exp;
        req <= '{1'h1, 1'h1, we, 4'hF, adr, {24'h0, d}};
        @(posedge clk_i);
        cap_r <= trig;
        do @(posedge clk_i); while (wb_ack !== 1'h1);
        rdat = wb_dat;
        cap_r <= 1'h0;
        req <= '0;
        exp = (adr == `TOMG_OFS_OUT_MASTER_EN) ? ome_m :
              (adr == `TOMG_OFS_OUT_CONTROL) ? ocr_m :
              (adr == `TOMG_OFS_COMBO_MODE) ? {6'h00, mode_m} : 8'h00;
        if (!we) begin
            chk("read", rdat, {24'h0, exp});
        end
        if (we && adr == `TOMG_OFS_OUT_MASTER_EN) ome_m = d | `TOMG_OME_FIXED_ONES;
        if (we && adr == `TOMG_OFS_OUT_CONTROL) ocr_m = d | `TOMG_OCR_FIXED_ONES;
        if (we && adr == `TOMG_OFS_COMBO_MODE) mode_m = d[1:0];
        // A capture event wins over the write and clears all six enables.
        if (trig && mode_m[1] && !ocr_m[4]) ome_m = `TOMG_OME_FIXED_ONES;
        @(posedge clk_i);
    endtask : acc

    task automatic pins_chk();
        logic [5:0] en, inv, eo, ee;
        en = ome_m[5:0];
        inv = mode_m[1] ? {{3{~ocr_m[0]}}, {3{~ocr_m[1]}}} : 6'h00;
        eo = (en & (tout ^ inv)) | (~en & gout);
        ee = (en & toe) | (~en & goe);
        chk("pins", {20'h0, pins}, {20'h0, eo, ee});
        chk("level", {26'h0, lvl}, {26'h0, eo & ee});
        chk("mode", {30'h0, combo}, {30'h0, mode_m});
    endtask : pins_chk

    // Free-running clock.
    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    // A hang is cut short well past the roughly 730 cycles the sequence needs.
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        {rst_i, standby_i, cap_r, req, tout, toe, gout, goe} = '0;
        rst_i = 1'h1;
        {err_total, n_tests, cyc_n} = '0;
        seed = 32'hBFB4;
        {ome_m, ocr_m, mode_m} = {8'hFF, 8'hFF, 2'h0};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        acc(1'h0, `TOMG_OFS_OUT_MASTER_EN, 8'h00, 1'h0);
        acc(1'h0, `TOMG_OFS_OUT_CONTROL, 8'h00, 1'h0);
        acc(1'h0, 4'hC, 8'h00, 1'h0);
        // Random gating across all four combination modes.
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            acc(1'h1, `TOMG_OFS_COMBO_MODE, {6'h0, i[1:0]}, 1'h0);
            acc(1'h1, `TOMG_OFS_OUT_MASTER_EN, seed[7:0], 1'h0);
            acc(1'h1, `TOMG_OFS_OUT_CONTROL, seed[15:8], 1'h0);
            acc(1'h0, `TOMG_OFS_OUT_MASTER_EN, 8'h00, 1'h0);
            seed = lfsr(seed);
            {tout, toe, gout, goe} <= seed[23:0];
            repeat (2) @(posedge clk_i);
            pins_chk();
        end
        // Capture trigger in every mode with the disable bit both ways.
        for (int m = 0; m < 8; m++) begin
            acc(1'h1, `TOMG_OFS_COMBO_MODE, {6'h0, m[1:0]}, 1'h0);
            acc(1'h1, `TOMG_OFS_OUT_CONTROL, {3'h0, m[2], 4'h0}, 1'h0);
            acc(1'h1, `TOMG_OFS_OUT_MASTER_EN, 8'hFF, 1'h0);
            acc(1'h0, `TOMG_OFS_OUT_CONTROL, 8'h00, 1'h1);
            acc(1'h0, `TOMG_OFS_OUT_MASTER_EN, 8'h00, 1'h0);
            pins_chk();
        end
        // Write and capture land on the same edge.
        acc(1'h1, `TOMG_OFS_COMBO_MODE, 8'h02, 1'h0);
        acc(1'h1, `TOMG_OFS_OUT_CONTROL, 8'h00, 1'h0);
        acc(1'h1, `TOMG_OFS_OUT_MASTER_EN, 8'hFF, 1'h1);
        acc(1'h0, `TOMG_OFS_OUT_MASTER_EN, 8'h00, 1'h0);
        acc(1'h0, `TOMG_OFS_COMBO_MODE, 8'h00, 1'h0);
        // Standby returns the enable and control registers to all ones and the mode to zero.
        standby_i <= 1'h1;
        @(posedge clk_i);
        standby_i <= 1'h0;
        @(posedge clk_i);
        {ome_m, ocr_m, mode_m} = {8'hFF, 8'hFF, 2'h0};
        acc(1'h0, `TOMG_OFS_OUT_MASTER_EN, 8'h00, 1'h0);
        acc(1'h0, `TOMG_OFS_OUT_CONTROL, 8'h00, 1'h0);
        pins_chk();
        close_out();
    end
endmodule : tb

`default_nettype wire
